// ---- testbench/ppr_pin_model.sv ----
// ppr_pin_model: system logic that drives the clock pin and sum terms.
// assumes the bench asks for one clock pin edge at a time through tick.
`timescale 1ns/10ps
module ppr_pin_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the bench
  input wire logic tick,
  input wire logic [1:0] hold,
  input wire logic [7:0] sumNext,
  // device pins
  output logic clkPin,
  output logic [7:0] sumTerm
);
  logic [1:0] stQ;
  logic [1:0] cntQ;

  // sum terms settle first, then one clock pin pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stQ <= 2'h0;
      cntQ <= 2'h0;
      clkPin <= 1'b0;
      sumTerm <= 8'h00;
    end else begin
      case (stQ)
        2'h0: if (tick) begin
          sumTerm <= sumNext;
          cntQ <= hold;
          stQ <= 2'h1;
        end
        2'h1: begin
          if (cntQ == 2'h0) begin
            stQ <= 2'h2;
          end else begin
            cntQ <= cntQ - 2'h1;
          end
        end
        2'h2: begin
          clkPin <= 1'b1;
          stQ <= 2'h3;
        end
        default: begin
          clkPin <= 1'b0;
          stQ <= 2'h0;
        end
      endcase
    end
  end
endmodule

// ---- testbench/ppr_power_reset_control_tb.sv ----
// ppr_power_reset_control_tb: self-checking bench of the block.
// assumes ppr_pkg and the pin model are compiled before it.
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  errCount++; $display("mismatch %s exp %h got %h", n, e, a); end end
module ppr_power_reset_control_tb;
  import ppr_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, clkPin, powerDown, er, tick = 0;
  logic oePin_n = 0;
  logic sleepReqPin = 0;
  logic [7:0] inPin = 8'h00;
  logic [7:0] ioIn = 8'h00;
  logic [7:0] oeTerm = 8'h00;
  logic [7:0] sumNext = 8'h00;
  logic [1:0] hold = 2'h0;
  logic [7:0] ioOut, ioOe_n, fbReg, sumTerm, v, held, oeH;
  logic [16:0] arrayIn, arrH;
  logic [15:0] cfg;
  logic [63:0] sig;
  int errCount = 0;
  int compares = 0;
  int seed = 32'h8da7_d7ee;

  // 125 MHz clock
  always #4 clk = ~clk;

  ppr_power_reset_control i_ppr_power_reset_control (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clkPin(clkPin), .oePin_n(oePin_n),
    .sleepReqPin(sleepReqPin), .inPin(inPin), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe_n(ioOe_n), .sumTerm(sumTerm), .oeTerm(oeTerm),
    .arrayIn(arrayIn), .fbReg(fbReg), .powerDown(powerDown));
  ppr_pin_model i_ppr_pin_model (.clk(clk), .rst_n(rst_n), .tick(tick),
    .hold(hold), .sumNext(sumNext), .clkPin(clkPin), .sumTerm(sumTerm));

  // expected verify word
  function automatic logic [31:0] verWord(logic [15:0] c, logic [2:0] t);
    return {13'h0000, c, t};
  endfunction

  // one apb transfer, held until pready seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) errCount++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // read and compare data and error flag
  task automatic chkRd(string n, logic [7:0] a, logic [31:0] e, logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rd)
    `CHK(n, ee, er)
  endtask

  // one clock pin edge through the model
  task automatic pulse;
    tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    repeat (8 + hold) @(posedge clk);
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("errors %0d compares %0d", errCount, compares);
    if (errCount == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    complete_run;
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    `CHK("ioOut", 8'hFF, ioOut)
    `CHK("ioOe_n", 8'hFF, ioOe_n)
    rst_n <= 1'b1;
    @(posedge clk);
    chkRd("status", OFF_STATUS, 32'h0000_0001, 1'b0);
    repeat (80) @(posedge clk);
    chkRd("status", OFF_STATUS, 32'h0000_0000, 1'b0);
    chkRd("mccfg", OFF_MCCFG, 32'h0000_0000, 1'b0);
    chkRd("siglo", OFF_SIGLO, 32'h0000_0000, 1'b0);
    repeat (6) begin
      sumNext <= 8'($random(seed));
      hold <= 2'($random(seed));
      oePin_n <= 1'($random(seed));
      inPin <= 8'($random(seed));
      oeTerm <= 8'($random(seed));
      pulse;
      `CHK("fbReg", sumNext, fbReg)
      `CHK("ioOut", ~sumNext, ioOut)
      `CHK("ioOe_n", {8{oePin_n}}, ioOe_n)
    end
    for (int k = 0; k < 3; k++) begin
      v = k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($random(seed)) | 8'h01;
      apb(1'b1, OFF_MCREG, {24'h00_0000, v});
      `CHK("preload", v, fbReg)
      chkRd("mcreg", OFF_MCREG, {24'h00_0000, v}, 1'b0);
    end
    sleepReqPin <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("arrayIn", 1'b1, arrayIn[16])
    `CHK("powerDown", 1'b0, powerDown)
    sleepReqPin <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    held = fbReg;
    v = ioOut;
    sleepReqPin <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("powerDown", 1'b1, powerDown)
    arrH = arrayIn;
    oeH = ioOe_n;
    inPin <= ~inPin;
    ioIn <= ~ioIn;
    oePin_n <= ~oePin_n;
    sumNext <= ~held;
    pulse;
    `CHK("fbReg", held, fbReg)
    `CHK("ioOut", v, ioOut)
    `CHK("ioOe_n", oeH, ioOe_n)
    `CHK("arrayIn", arrH, arrayIn)
    apb(1'b1, OFF_MCREG, 32'h0000_00A5);
    `CHK("pslverr", 1'b1, er)
    sleepReqPin <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("powerDown", 1'b0, powerDown)
    `CHK("fbReg", held, fbReg)
    pulse;
    `CHK("fbReg", ~held, fbReg)
    for (int m = 0; m < 3; m++) begin
      cfg = 16'($random(seed));
      apb(1'b1, OFF_MCCFG, {16'h0000, cfg});
      apb(1'b1, OFF_CTRL, 32'(m));
      chkRd("verify", OFF_VERIFY, verWord(cfg, 3'(m)), 1'b0);
    end
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_MCCFG, k ? 32'h0000_AAAA : 32'h0000_FFFF);
      @(posedge clk);
      `CHK("ioOe_n", k ? 8'h00 : 8'hFF, ioOe_n)
    end
    // complex mode comb i/o follows its term, simple mode always drives
    oeTerm <= 8'($random(seed));
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    apb(1'b1, OFF_MCCFG, 32'h0000_5555);
    @(posedge clk);
    `CHK("ioOe_n", ~oeTerm, ioOe_n)
    `CHK("ioOut", sumNext, ioOut)
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    @(posedge clk);
    `CHK("ioOe_n", 8'h00, ioOe_n)
    sig = {$random(seed), $random(seed)};
    apb(1'b1, OFF_SIGLO, sig[31:0]);
    apb(1'b1, OFF_SIGHI, sig[63:32]);
    apb(1'b1, OFF_SECURE, 32'h0000_0001);
    chkRd("status", OFF_STATUS, 32'h0000_0004, 1'b0);
    chkRd("mcreg", OFF_MCREG, 32'h0000_0000, 1'b1);
    held = fbReg;
    apb(1'b1, OFF_MCREG, 32'h0000_0077);
    `CHK("fbReg", held, fbReg)
    chkRd("verify", OFF_VERIFY, 32'h0000_0000, 1'b1);
    chkRd("siglo", OFF_SIGLO, sig[31:0], 1'b0);
    chkRd("sighi", OFF_SIGHI, sig[63:32], 1'b0);
    chkRd("unmapped", 8'h20, 32'h0000_0000, 1'b1);
    // mid-run reset clears cells and the fuse, restarts power-up
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("fbReg", 8'h00, fbReg)
    `CHK("ioOut", 8'hFF, ioOut)
    rst_n <= 1'b1;
    @(posedge clk);
    chkRd("status", OFF_STATUS, 32'h0000_0001, 1'b0);
    complete_run;
  end
endmodule

// ---- verilog/ppr_pkg.sv ----
// ppr_pkg: register map, field layout, encodings and timing counts
// of the power and reset control block; assumes a 125 MHz clock.
package ppr_pkg;
  // apb register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MCCFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MCREG = 8'h0C;
  localparam logic [7:0] OFF_SIGLO = 8'h10;
  localparam logic [7:0] OFF_SIGHI = 8'h14;
  localparam logic [7:0] OFF_SECURE = 8'h18;
  localparam logic [7:0] OFF_VERIFY = 8'h1C;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PDEN_BIT = 2;
  localparam int STAT_POR_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_SEC_BIT = 2;
  localparam int VER_CFG_LSB = 3;
  // reset values
  localparam logic [31:0] SIG_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // architecture modes
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_COMPLEX = 2'h1;
  localparam logic [1:0] MODE_SIMPLE = 2'h2;
  // macrocell configurations
  localparam logic [1:0] MC_REGOUT = 2'h0;
  localparam logic [1:0] MC_COMBIO = 2'h1;
  localparam logic [1:0] MC_COMBOUT = 2'h2;
  localparam logic [1:0] MC_INPUT = 2'h3;
  // power-up reset interval
  localparam int CLK_PERIOD_NS = 8;
  localparam int POR_TIME_NS = 600;
  localparam int POR_CYCLES =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W = 7;
  localparam logic [POR_W-1:0] POR_LAST = 7'(POR_CYCLES - 1);
  // power state
  typedef enum logic [1:0] {
    PS_POR = 2'b00,
    PS_RUN = 2'b01,
    PS_SLEEP = 2'b10
  } ppr_pstate_e;
endpackage

// ---- verilog/ppr_power_reset_control.sv ----
// ppr_power_reset_control: macrocell registers, power-up reset,
// pin power-down, preload, security and user signature behind apb.
// assumes all pins synchronous to clk; array terms come from outside.
`timescale 1ns/10ps
// Operation
// R1 - reset clears registers, registered outputs high
// R2 - system meets setup before first clock
// R3 - clock source stable during power-up interval
// R4 - enabled sleep pin high enters power-down
// R5 - power-down freezes state and outputs
// R6 - high impedance outputs stay released
// R7 - power-down ignores all inputs except sleep
// R8 - pins keep last level in power-down
// R9 - sleep pin plain input when disabled
// R10 - preload forces any register value
// R11 - secured part refuses verify and preload
// R12 - user signature readable regardless of security
// R13 - programmer sets security fuse last
// R14 - eight macrocells, four configurations each
// R15 - exactly one of three architecture modes
// R16 - registered cells use clock and oe pins
// R17 - wake resumes held state without reset
module ppr_power_reset_control #(
  parameter int NMC = 8,
  parameter int NIN = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  input wire logic clkPin,
  input wire logic oePin_n,
  input wire logic sleepReqPin,
  input wire logic [NIN-1:0] inPin,
  input wire logic [NMC-1:0] ioIn,
  output logic [NMC-1:0] ioOut,
  output logic [NMC-1:0] ioOe_n,
  // logic array side
  input wire logic [NMC-1:0] sumTerm,
  input wire logic [NMC-1:0] oeTerm,
  output logic [NIN+NMC:0] arrayIn,
  output logic [NMC-1:0] fbReg,
  output logic powerDown
);
  import ppr_pkg::*;

  // register cell: registered config in registered mode
  function automatic logic isRegCell(logic [1:0] m, logic [1:0] c);
    return (m == MODE_REG) && (c == MC_REGOUT);
  endfunction

  // driver enable per macrocell configuration and mode
  function automatic logic drvEn(logic [1:0] m, logic [1:0] c,
                                 logic oeN, logic t);
    if (c == MC_INPUT) begin
      return 1'b0;
    end
    if (isRegCell(m, c)) begin
      return !oeN;
    end
    if (c == MC_COMBOUT || m == MODE_SIMPLE || m == 2'h3) begin
      return 1'b1;
    end
    return t;
  endfunction

  logic [1:0] modeQ, modeD;
  logic pdEnQ, pdEnD;
  logic [2*NMC-1:0] mcCfgQ, mcCfgD;
  logic secQ, secD;
  logic [63:0] sigQ, sigD;
  logic [31:0] prdataQ, prdataD;
  logic preadyQ, preadyD;
  logic pslverrQ, pslverrD;
  logic acc, done, preloadEn;
  logic [NMC-1:0] preloadVal;
  ppr_pstate_e psQ, psD;
  logic [POR_W-1:0] porCntQ, porCntD;
  logic clkPrevQ, clkPrevD, clkRise;
  logic powerDownQ, powerDownD;
  logic [NMC-1:0] regQ, regD;
  logic [NMC-1:0] ioOutQ, ioOutD, ioOeQ, ioOeD;
  logic [NIN+NMC:0] arrayInQ, arrayInD;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // apb handshake: one wait cycle, write lands on pready edge
  assign acc = psel && penable;
  assign done = acc && preadyQ;
  assign preloadEn = done && pwrite && paddr == OFF_MCREG &&
                     !secQ && psQ != PS_SLEEP; // R11 R10
  assign preloadVal = pwdata[NMC-1:0];

  // register file next values and read data
  always_comb begin
    modeD = modeQ;
    pdEnD = pdEnQ;
    mcCfgD = mcCfgQ;
    secD = secQ;
    sigD = sigQ;
    preadyD = acc && !preadyQ;
    prdataD = RD_ZERO;
    pslverrD = 1'b0;
    if (acc && !preadyQ) begin
      unique case (paddr)
        OFF_CTRL: prdataD[2:0] = {pdEnQ, modeQ};
        OFF_MCCFG: prdataD[2*NMC-1:0] = mcCfgQ;
        OFF_STATUS: begin
          prdataD[STAT_POR_BIT] = psQ == PS_POR;
          prdataD[STAT_SLEEP_BIT] = psQ == PS_SLEEP;
          prdataD[STAT_SEC_BIT] = secQ;
        end
        OFF_MCREG: begin
          pslverrD = secQ || (pwrite && psQ == PS_SLEEP); // R11
          prdataD[NMC-1:0] = secQ ? '0 : regQ;
        end
        OFF_SIGLO: prdataD = sigQ[31:0]; // R12
        OFF_SIGHI: prdataD = sigQ[63:32]; // R12
        OFF_SECURE: prdataD[0] = secQ;
        OFF_VERIFY: begin
          pslverrD = secQ; // R11
          if (!secQ) begin
            prdataD[VER_CFG_LSB+2*NMC-1:0] = {mcCfgQ, pdEnQ, modeQ};
          end
        end
        default: pslverrD = 1'b1;
      endcase
    end else if (acc) begin
      prdataD = prdataQ;
      pslverrD = pslverrQ;
    end
    if (done && pwrite) begin
      unique case (paddr)
        OFF_CTRL: begin
          modeD = pwdata[CTRL_MODE_LSB+:2]; // R15
          pdEnD = pwdata[CTRL_PDEN_BIT];
        end
        OFF_MCCFG: mcCfgD = pwdata[2*NMC-1:0]; // R14
        OFF_SIGLO: sigD[31:0] = pwdata;
        OFF_SIGHI: sigD[63:32] = pwdata;
        OFF_SECURE: secD = secQ || pwdata[0]; // R13
        default: secD = secQ;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeQ <= MODE_REG;
      pdEnQ <= 1'b0;
      mcCfgQ <= '0;
      secQ <= 1'b0;
      sigQ <= {SIG_RESET, SIG_RESET};
      prdataQ <= RD_ZERO;
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
    end else begin
      modeQ <= modeD;
      pdEnQ <= pdEnD;
      mcCfgQ <= mcCfgD;
      secQ <= secD;
      sigQ <= sigD;
      prdataQ <= prdataD;
      preadyQ <= preadyD;
      pslverrQ <= pslverrD;
    end
  end

  // power state: power-up interval, sleep entry and wake
  always_comb begin
    psD = psQ;
    porCntD = porCntQ;
    unique case (psQ)
      PS_POR: begin
        porCntD = porCntQ + 7'd1;
        if (porCntQ == POR_LAST) begin
          psD = PS_RUN; // R3
        end
      end
      PS_RUN: begin
        if (pdEnQ && sleepReqPin) begin
          psD = PS_SLEEP; // R4
        end
      end
      PS_SLEEP: begin
        if (!(pdEnQ && sleepReqPin)) begin
          psD = PS_RUN; // R17
        end
      end
      default: psD = PS_POR;
    endcase
    powerDownD = psD == PS_SLEEP; // R4
  end

  // macrocells, pin drivers and array inputs
  always_comb begin
    clkPrevD = clkPin;
    clkRise = clkPin && !clkPrevQ;
    regD = regQ;
    ioOutD = ioOutQ;
    ioOeD = ioOeQ;
    arrayInD = arrayInQ;
    if (preloadEn) begin
      regD = preloadVal; // R10
    end else if (psQ == PS_RUN && clkRise) begin
      for (int i = 0; i < NMC; i++) begin
        if (isRegCell(modeQ, mcCfgQ[2*i+:2])) begin
          regD[i] = sumTerm[i]; // R16
        end
      end
    end
    if (psQ != PS_SLEEP) begin
      for (int i = 0; i < NMC; i++) begin
        ioOutD[i] = isRegCell(modeQ, mcCfgQ[2*i+:2]) ?
                    !regQ[i] : sumTerm[i]; // R1
        ioOeD[i] = !drvEn(modeQ, mcCfgQ[2*i+:2], oePin_n,
                          oeTerm[i]); // R14 R16
      end
      arrayInD = {pdEnQ ? 1'b0 : sleepReqPin, ioIn, inPin}; // R9
    end
  end

  // power and macrocell flops; sleep holds cells, pin drivers and array inputs, clkPrevQ keeps tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psQ <= PS_POR;
      powerDownQ <= 1'b0;
      porCntQ <= '0;
      clkPrevQ <= 1'b0;
      regQ <= '0; // R1
      ioOutQ <= '1;
      ioOeQ <= '1;
      arrayInQ <= '0;
    end else begin
      psQ <= psD;
      powerDownQ <= powerDownD;
      porCntQ <= porCntD;
      clkPrevQ <= clkPrevD;
      regQ <= regD;
      ioOutQ <= ioOutD; // R5
      ioOeQ <= ioOeD; // R6
      arrayInQ <= arrayInD; // R7 R8
    end
  end

  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = pslverrQ;
  assign ioOut = ioOutQ;
  assign ioOe_n = ioOeQ;
  assign arrayIn = arrayInQ;
  assign fbReg = regQ;
  assign powerDown = powerDownQ;

  // assertion sequences
  sequence sSleepReq;
    psQ == PS_RUN && pdEnQ && sleepReqPin;
  endsequence
  sequence sWake;
    psQ == PS_SLEEP && !sleepReqPin;
  endsequence

  a_reset_clears: assert property (disable iff (1'b0) // R1
    !rst_n |=> regQ == '0 && ioOutQ == '1 && psQ == PS_POR)
    else $error("reset did not clear macrocells");
  a_por_length: assert property ( // R3
    psQ == PS_POR && porCntQ == POR_LAST |=> psQ == PS_RUN)
    else $error("power-up interval wrong length");
  a_sleep_enter: assert property ( // R4
    sSleepReq |=> psQ == PS_SLEEP ##0 powerDown)
    else $error("sleep request not honoured");
  a_sleep_freeze: assert property ( // R5
    psQ == PS_SLEEP |=> $stable(regQ) && $stable(ioOutQ))
    else $error("state changed in power-down");
  a_hiz_hold: assert property ( // R6
    psQ == PS_SLEEP |=> $stable(ioOe_n))
    else $error("output enable changed in power-down");
  a_input_block: assert property ( // R7
    psQ == PS_SLEEP |=> $stable(arrayIn))
    else $error("inputs passed in power-down");
  a_pin_plain: assert property ( // R9
    psQ == PS_RUN && !pdEnQ |=>
      psQ == PS_RUN && arrayIn[NIN+NMC] == $past(sleepReqPin))
    else $error("sleep pin not a plain input");
  a_preload_load: assert property ( // R10
    preloadEn |=> regQ == $past(preloadVal))
    else $error("preload value not loaded");
  a_secure_block: assert property ( // R11
    secQ && acc && !preadyQ && paddr == OFF_MCREG |=>
      pready && pslverr && !preloadEn ##1 $stable(regQ))
    else $error("secured preload not refused");
  a_sig_read: assert property ( // R12
    acc && !preadyQ && !pwrite && paddr == OFF_SIGLO |=>
      pready && !pslverr && prdata == sigQ[31:0])
    else $error("signature not readable");
  a_reg_clock: assert property ( // R16
    psQ == PS_RUN && clkRise && !preloadEn &&
    isRegCell(modeQ, mcCfgQ[1:0]) |=> regQ[0] == $past(sumTerm[0]))
    else $error("registered cell missed clock");
  a_wake_resume: assert property ( // R17
    sWake |=> psQ == PS_RUN && $stable(regQ))
    else $error("wake did not resume held state");
endmodule
